// file: cse_pkg.sv
package cse_pkg;
  localparam int NUM_STATES = 4;
  localparam int NUM_FIELDS = 5;
  // Register indices; byte address is four times the index
  localparam logic [6:0] IX_RSVD_PTR  = 7'h00;
  localparam logic [6:0] IX_WIN_ORG   = 7'h02;
  localparam logic [6:0] IX_WIN_DIM   = 7'h03;
  localparam logic [6:0] IX_WAKE_ROW  = 7'h04;
  localparam logic [6:0] IX_GOAL      = 7'h06;
  localparam logic [6:0] IX_TOLERANCE = 7'h07;
  localparam logic [6:0] IX_UPD_RATE  = 7'h08;
  localparam logic [6:0] IX_STEP_DIV  = 7'h09;
  localparam logic [6:0] IX_SEQ_CMD   = 7'h3e;
  localparam logic [6:0] IX_BANK_STAT = 7'h3f;
  localparam logic [6:0] IX_PS [NUM_STATES][NUM_FIELDS] = '{
    '{7'h22, 7'h23, 7'h24, 7'h26, 7'h28}, '{7'h29, 7'h2a, 7'h2b, 7'h2d, 7'h2f},
    '{7'h30, 7'h31, 7'h32, 7'h34, 7'h36}, '{7'h37, 7'h38, 7'h39, 7'h3b, 7'h3d}};
  localparam logic [7:0] RST_PS [NUM_STATES][NUM_FIELDS] = '{
    '{8'h01, 8'h00, 8'h01, 8'h01, 8'h00}, '{8'h03, 8'h02, 8'h03, 8'h03, 8'h00},
    '{8'h04, 8'h00, 8'h01, 8'h01, 8'h00}, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00}};
  localparam logic [15:0] RST_RSVD_PTR = 16'he87e;
  localparam logic [7:0]  RST_WIN_ORG  = 8'h00;
  localparam logic [7:0]  RST_WIN_DIM  = 8'hef;
  localparam logic [7:0]  RST_GOAL     = 8'h3c;
  localparam logic [7:0]  RST_TOL      = 8'h0a;
  localparam logic [7:0]  RST_RATE     = 8'h00;
  localparam logic [7:0]  RST_STEP     = 8'h02;
  localparam logic [7:0]  CMD_REFRESH  = 8'h06;
  localparam logic [15:0] FRAME_ROWS_DFLT = 16'h04b0;
  localparam int F_EXP = 0;
  localparam int F_FLK = 1;
  localparam int F_BAL = 2;
  localparam int F_HIS = 3;
  localparam int F_SKIP = 4;
  localparam int SKIP_FEN_BIT = 7;
  localparam int SKIP_STATE_BIT = 6;
  localparam int SKIP_LED_BIT = 5;
  localparam int STAT_UNMAP_BIT = 3;

  typedef enum logic [4:0] {EXP_OFF = 5'h01, EXP_FAST = 5'h02, EXP_MANUAL = 5'h04,
                            EXP_CONT = 5'h08, EXP_FAST_METER = 5'h10} cse_exp_t;
  typedef enum logic [2:0] {FLK_OFF = 3'h1, FLK_MANUAL = 3'h2, FLK_CONT = 3'h4} cse_flk_t;
  typedef enum logic [3:0] {BAL_OFF = 4'h1, BAL_FAST = 4'h2, BAL_MANUAL = 4'h4,
                            BAL_CONT = 4'h8} cse_bal_t;
  typedef enum logic [3:0] {HIS_OFF = 4'h1, HIS_FAST = 4'h2, HIS_MANUAL = 4'h4,
                            HIS_CONT = 4'h8} cse_his_t;
  typedef enum logic [2:0] {BUS_IDLE = 3'h1, BUS_RD = 3'h2, BUS_ACK = 3'h4} cse_bus_st_t;

  // Hit flag, state and field of a per-state index
  function automatic logic [5:0] ps_lookup(input logic [6:0] ix);
    ps_lookup = 6'h00;
    for (int s = 0; s < NUM_STATES; s++) begin
      for (int f = 0; f < NUM_FIELDS; f++) begin
        if (IX_PS[s][f] == ix) begin
          ps_lookup = {1'b1, 2'(s), 3'(f)};
        end
      end
    end
  endfunction

  // Row just below the bottom of the window grid
  function automatic logic [15:0] wake_of(input logic [7:0] org, input logic [7:0] dim,
                                          input logic [15:0] rows);
    logic [6:0]  span;
    logic [22:0] prod;
    span = {3'h0, org[7:4]} + {1'b0, dim[7:4], 2'h0} + 7'h04;
    prod = 23'(span) * 23'(rows);
    wake_of = prod[19:4];
  endfunction
endpackage

// file: cse_cfg_if.sv
`timescale 1ns/100ps
`default_nettype none
interface cse_cfg_if;
  logic                                  wr_en;
  logic [1:0]                            wr_state;
  logic [2:0]                            wr_field;
  logic [7:0]                            wr_data;
  logic [1:0]                            rd_state;
  logic [2:0]                            rd_field;
  logic [7:0]                            rd_data;
  logic [1:0]                            act_state;
  logic [cse_pkg::NUM_FIELDS-1:0][7:0]   act_fld;
  modport store (input wr_en, wr_state, wr_field, wr_data, rd_state, rd_field, act_state,
                 output rd_data, act_fld);
  modport ctrl (output wr_en, wr_state, wr_field, wr_data, rd_state, rd_field, act_state,
                input rd_data, act_fld);
endinterface // cse_cfg_if
`default_nettype wire

// file: cse_state_mem.sv
`timescale 1ns/100ps
`default_nettype none
module cse_state_mem import cse_pkg::*; #(
  parameter int NS = NUM_STATES,
  parameter int NF = NUM_FIELDS
) (
  input  wire logic  clk_sys,
  input  wire logic  rst_n,
  cse_cfg_if.store   cfg
);
  logic [7:0] mem_r [NS][NF];

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  for (genvar s = 0; s < NS; s++) begin : g_state
    for (genvar f = 0; f < NF; f++) begin : g_field
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          mem_r[s][f] <= RST_PS[s][f];
        end else if (cfg.wr_en && cfg.wr_state == 2'(s) && cfg.wr_field == 3'(f)) begin
          mem_r[s][f] <= cfg.wr_data;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cfg.rd_data <= 8'h00;
    end else begin
      cfg.rd_data <= (cfg.rd_field < 3'(NF)) ? mem_r[cfg.rd_state][cfg.rd_field] : 8'h00;
    end
  end

  always_ff @(posedge clk_sys) begin
    for (int f = 0; f < NF; f++) begin
      cfg.act_fld[f] <= rst_n ? mem_r[cfg.act_state][f] : 8'h00;
    end
  end

  a_live_defaults: assert property ($rose(rst_n) |-> mem_r[1][0] == 8'h03 &&
    mem_r[1][1] == 8'h02 && mem_r[1][2] == 8'h03 && mem_r[1][3] == 8'h03)
    else $error("live view mode defaults wrong");
  a_exit_defaults: assert property ($rose(rst_n) |-> mem_r[2][0] == 8'h04 &&
    mem_r[2][1] == 8'h00 && mem_r[0][0] == 8'h01 && mem_r[0][1] == 8'h00)
    else $error("entry or exit mode defaults wrong");
  a_still_zero: assert property ($rose(rst_n) |-> mem_r[3][0] == 8'h00 &&
    mem_r[3][2] == 8'h00 && mem_r[3][3] == 8'h00 && mem_r[3][4] == 8'h00)
    else $error("still entry settings not zero");
endmodule // cse_state_mem
`default_nettype wire

// file: cse_win_unit.sv
`timescale 1ns/100ps
`default_nettype none
module cse_win_unit import cse_pkg::*; #(
  parameter logic [15:0] FRAME_ROWS = FRAME_ROWS_DFLT
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [7:0]  shadow_org,
  input  wire logic [7:0]  shadow_dim,
  input  wire logic        refresh,
  output logic [7:0]       act_org_r,
  output logic [7:0]       act_dim_r,
  output logic [15:0]      wake_r
);
  localparam logic [15:0] WAKE_RST = wake_of(RST_WIN_ORG, RST_WIN_DIM, FRAME_ROWS);

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      act_org_r <= RST_WIN_ORG;
      act_dim_r <= RST_WIN_DIM;
    end else if (refresh) begin
      act_org_r <= shadow_org;
      act_dim_r <= shadow_dim;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wake_r <= WAKE_RST;
    end else begin
      wake_r <= wake_of(act_org_r, act_dim_r, FRAME_ROWS);
    end
  end

  a_window_hold: assert property (!refresh |=> $stable(act_org_r) && $stable(act_dim_r))
    else $error("active window changed without refresh");
  a_refresh_copy: assert property (refresh |=> act_org_r == $past(shadow_org) &&
    act_dim_r == $past(shadow_dim)) else $error("refresh did not load window");
  a_wake_update: assert property (refresh |=> ##1 wake_r ==
    wake_of($past(shadow_org, 2), $past(shadow_dim, 2), FRAME_ROWS))
    else $error("wake row not recomputed");
endmodule // cse_win_unit
`default_nettype wire

// file: cse_bank_top.sv
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Exposure mode: 0 off, 1 fast, 2 manual, 3 continuous, 4 fast plus metering.
// - Flicker mode: 0 off, 1 manual, 2 continuous.
// - White balance mode: 0 off, 1 fast, 2 manual, 3 continuous.
// - Histogram mode: 0 off, 1 fast, 2 manual, 3 continuous.
// - Skip byte bit 7 turns frame enable off in that state.
// - Skip byte bit 6 makes the sequencer skip that state.
// - Skip byte bit 5 drops the first frame while the LED is on.
// - Live view modes reset to continuous: 3, 2, 3, 3.
// - Exit resets to 4,0,1,1; entry resets to 1,0,1,1.
// - Still entry modes and skip byte reset to zero.
// - Window origin: horizontal in bits 3:0, vertical in 7:4, sixteenths.
// - Window size: width 3:0, height 7:4, minus one; resets to 0xef.
// - Window values act only after command 6 is written.
// - Read-only wake row recomputed after each window change.
// - Exposure update rate resets to zero.
// - Exposure step divisor resets to two; one is fastest.
module cse_bank_top import cse_pkg::*; #(
  parameter logic [15:0] FRAME_ROWS = FRAME_ROWS_DFLT
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic [8:0]   avs_address,
  input  wire logic         avs_read,
  input  wire logic         avs_write,
  input  wire logic [31:0]  avs_writedata,
  input  wire logic [3:0]   avs_byteenable,
  output logic [31:0]       avs_readdata,
  output logic              avs_waitrequest,
  input  wire logic [1:0]   seq_state,
  input  wire logic         frame_start,
  input  wire logic         led_on,
  output var cse_exp_t      exp_mode,
  output var cse_flk_t      flk_mode,
  output var cse_bal_t      bal_mode,
  output var cse_his_t      his_mode,
  output logic              frame_enable,
  output logic              state_skip,
  output logic              frame_discard,
  output logic [3:0]        win_x_origin,
  output logic [3:0]        win_y_origin,
  output logic [3:0]        win_width_m1,
  output logic [3:0]        win_height_m1,
  output logic [15:0]       wake_row,
  output logic [7:0]        brightness_goal,
  output logic [7:0]        exposure_tolerance,
  output logic [7:0]        exposure_update_rate,
  output logic [7:0]        exposure_step_divisor
);
  cse_bus_st_t  bus_st_r;
  logic [6:0]   idx;
  logic         idx_ok;
  logic [5:0]   ps_w;
  logic         take_rd;
  logic         take_wr;
  logic         wr_ok;
  logic [31:0]  rd_mux;
  logic [7:0]   win_org_r;
  logic [7:0]   win_dim_r;
  logic [7:0]   cmd_r;
  logic         refresh_r;
  logic [1:0]   cur_state_r;
  logic         first_pend_r;
  logic         unmap_r;
  logic         unmap_hit;
  logic         unmap_clr;
  logic [7:0]   act_org;
  logic [7:0]   act_dim;
  logic [7:0]   skip_byte;

  cse_cfg_if cfg_if ();

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  assign idx = avs_address[8:2];
  assign idx_ok = (avs_address[1:0] == 2'h0);
  assign ps_w = ps_lookup(idx);
  assign take_rd = (bus_st_r == BUS_IDLE) && avs_read;
  assign take_wr = (bus_st_r == BUS_IDLE) && avs_write && !avs_read;
  // Only the low lane carries byte-wide registers
  assign wr_ok = take_wr && idx_ok && avs_byteenable[0];
  assign skip_byte = cfg_if.act_fld[F_SKIP];

  // Per-state settings store
  assign cfg_if.wr_en = wr_ok && ps_w[5];
  assign cfg_if.wr_state = ps_w[4:3];
  assign cfg_if.wr_field = ps_w[2:0];
  assign cfg_if.wr_data = avs_writedata[7:0];
  assign cfg_if.rd_state = ps_w[4:3];
  assign cfg_if.rd_field = ps_w[5] ? ps_w[2:0] : 3'h7;
  assign cfg_if.act_state = seq_state;

  cse_state_mem #(
    .NS (NUM_STATES),
    .NF (NUM_FIELDS)
  ) u_state_mem (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .cfg     (cfg_if.store)
  );

  cse_win_unit #(
    .FRAME_ROWS (FRAME_ROWS)
  ) u_win_unit (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .shadow_org (win_org_r),
    .shadow_dim (win_dim_r),
    .refresh    (refresh_r),
    .act_org_r  (act_org),
    .act_dim_r  (act_dim),
    .wake_r     (wake_row)
  );

  assign win_x_origin = act_org[3:0];
  assign win_y_origin = act_org[7:4];
  assign win_width_m1 = act_dim[3:0];
  assign win_height_m1 = act_dim[7:4];

  // Bus handshake: writes answer at edge 1, reads at edge 2
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      bus_st_r <= BUS_IDLE;
      avs_waitrequest <= 1'b1;
    end else begin
      case (bus_st_r)
        BUS_IDLE: begin
          if (take_rd) begin
            bus_st_r <= BUS_RD;
          end else if (take_wr) begin
            bus_st_r <= BUS_ACK;
            avs_waitrequest <= 1'b0;
          end
        end
        BUS_RD: begin
          bus_st_r <= BUS_ACK;
          avs_waitrequest <= 1'b0;
        end
        BUS_ACK: begin
          bus_st_r <= BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default: begin
          bus_st_r <= BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // Read data select
  always_comb begin
    rd_mux = 32'h0;
    if (!idx_ok) begin
      rd_mux = 32'h0;
    end else if (ps_w[5]) begin
      rd_mux = {24'h0, cfg_if.rd_data};
    end else begin
      case (idx)
        IX_RSVD_PTR:  rd_mux = {16'h0, RST_RSVD_PTR};
        IX_WIN_ORG:   rd_mux = {24'h0, win_org_r};
        IX_WIN_DIM:   rd_mux = {24'h0, win_dim_r};
        IX_WAKE_ROW:  rd_mux = {16'h0, wake_row};
        IX_GOAL:      rd_mux = {24'h0, brightness_goal};
        IX_TOLERANCE: rd_mux = {24'h0, exposure_tolerance};
        IX_UPD_RATE:  rd_mux = {24'h0, exposure_update_rate};
        IX_STEP_DIV:  rd_mux = {24'h0, exposure_step_divisor};
        IX_SEQ_CMD:   rd_mux = {24'h0, cmd_r};
        IX_BANK_STAT: rd_mux = {28'h0, unmap_r, first_pend_r, cur_state_r};
        default:      rd_mux = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0;
    end else if (bus_st_r == BUS_RD) begin
      avs_readdata <= rd_mux;
    end
  end

  // Sticky flag for accesses that hit no register
  assign unmap_hit = (take_rd || take_wr) && (!idx_ok || (!ps_w[5] &&
                     !(idx inside {IX_RSVD_PTR, IX_WIN_ORG, IX_WIN_DIM, IX_WAKE_ROW,
                                   IX_GOAL, IX_TOLERANCE, IX_UPD_RATE, IX_STEP_DIV,
                                   IX_SEQ_CMD, IX_BANK_STAT})));
  assign unmap_clr = wr_ok && idx == IX_BANK_STAT && avs_writedata[STAT_UNMAP_BIT];

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      unmap_r <= 1'b0;
    end else if (unmap_hit) begin
      unmap_r <= 1'b1;
    end else if (unmap_clr) begin
      unmap_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      win_org_r <= RST_WIN_ORG;
      win_dim_r <= RST_WIN_DIM;
    end else if (wr_ok && idx == IX_WIN_ORG) begin
      win_org_r <= avs_writedata[7:0];
    end else if (wr_ok && idx == IX_WIN_DIM) begin
      win_dim_r <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      brightness_goal <= RST_GOAL;
      exposure_tolerance <= RST_TOL;
      exposure_update_rate <= RST_RATE;
      exposure_step_divisor <= RST_STEP;
    end else if (wr_ok) begin
      case (idx)
        IX_GOAL:      brightness_goal <= avs_writedata[7:0];
        IX_TOLERANCE: exposure_tolerance <= avs_writedata[7:0];
        IX_UPD_RATE:  exposure_update_rate <= avs_writedata[7:0];
        IX_STEP_DIV:  exposure_step_divisor <= avs_writedata[7:0];
        default:      brightness_goal <= brightness_goal;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cmd_r <= 8'h00;
      refresh_r <= 1'b0;
    end else if (wr_ok && idx == IX_SEQ_CMD) begin
      cmd_r <= avs_writedata[7:0];
      refresh_r <= (avs_writedata[7:0] == CMD_REFRESH);
    end else begin
      refresh_r <= 1'b0;
      if (refresh_r) begin
        cmd_r <= 8'h00;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      exp_mode <= EXP_OFF;
      flk_mode <= FLK_OFF;
      bal_mode <= BAL_OFF;
      his_mode <= HIS_OFF;
    end else begin
      case (cfg_if.act_fld[F_EXP])
        8'h01:   exp_mode <= EXP_FAST;
        8'h02:   exp_mode <= EXP_MANUAL;
        8'h03:   exp_mode <= EXP_CONT;
        8'h04:   exp_mode <= EXP_FAST_METER;
        default: exp_mode <= EXP_OFF;
      endcase
      case (cfg_if.act_fld[F_FLK])
        8'h01:   flk_mode <= FLK_MANUAL;
        8'h02:   flk_mode <= FLK_CONT;
        default: flk_mode <= FLK_OFF;
      endcase
      case (cfg_if.act_fld[F_BAL])
        8'h01:   bal_mode <= BAL_FAST;
        8'h02:   bal_mode <= BAL_MANUAL;
        8'h03:   bal_mode <= BAL_CONT;
        default: bal_mode <= BAL_OFF;
      endcase
      case (cfg_if.act_fld[F_HIS])
        8'h01:   his_mode <= HIS_FAST;
        8'h02:   his_mode <= HIS_MANUAL;
        8'h03:   his_mode <= HIS_CONT;
        default: his_mode <= HIS_OFF;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      frame_enable <= 1'b1;
      state_skip <= 1'b0;
    end else begin
      frame_enable <= !skip_byte[SKIP_FEN_BIT];
      state_skip <= skip_byte[SKIP_STATE_BIT];
    end
  end

  // First frame of each state; a new state wins over a frame start
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cur_state_r <= 2'h0;
      first_pend_r <= 1'b1;
    end else begin
      cur_state_r <= seq_state;
      if (seq_state != cur_state_r) begin
        first_pend_r <= 1'b1;
      end else if (frame_start) begin
        first_pend_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      frame_discard <= 1'b0;
    end else begin
      frame_discard <= frame_start && first_pend_r && led_on && skip_byte[SKIP_LED_BIT];
    end
  end

  sequence s_refresh_wr;
    wr_ok && idx == IX_SEQ_CMD && avs_writedata[7:0] == 8'h06;
  endsequence

  sequence s_read_taken;
    take_rd ##1 avs_waitrequest;
  endsequence

  a_exp_decode: assert property (cfg_if.act_fld[F_EXP] == 8'h04 |=> exp_mode == EXP_FAST_METER)
    else $error("exposure mode 4 not decoded");
  a_flk_decode: assert property (cfg_if.act_fld[F_FLK] == 8'h02 |=> flk_mode == FLK_CONT)
    else $error("flicker mode 2 not decoded");
  a_bal_decode: assert property (cfg_if.act_fld[F_BAL] == 8'h01 |=> bal_mode == BAL_FAST)
    else $error("balance mode 1 not decoded");
  a_his_decode: assert property (cfg_if.act_fld[F_HIS] == 8'h03 |=> his_mode == HIS_CONT)
    else $error("histogram mode 3 not decoded");
  a_frame_gating: assert property (skip_byte[7] |=> !frame_enable)
    else $error("frame enable not switched off");
  a_state_skip: assert property (state_skip |-> $past(skip_byte[6]))
    else $error("state skip without its bit");
  a_first_discard: assert property (frame_discard |-> $past(led_on) && $past(frame_start) &&
    $past(skip_byte[5]) && $past(first_pend_r)) else $error("frame discard without cause");
  a_cmd_refresh: assert property (s_refresh_wr |=> refresh_r ##1 !refresh_r)
    else $error("refresh command not one pulse");
  a_no_stray_refresh: assert property (refresh_r |-> $past(wr_ok) && $past(idx) == IX_SEQ_CMD)
    else $error("refresh without command write");
  a_dim_reset: assert property ($rose(rst_n) |-> win_dim_r == 8'hef && win_org_r == 8'h00)
    else $error("window size reset wrong");
  a_tuning_reset: assert property ($rose(rst_n) |-> exposure_update_rate == 8'h00 &&
    exposure_step_divisor == 8'h02) else $error("tuning reset wrong");
  a_read_answer: assert property (s_read_taken |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("read not answered at second edge");
endmodule // cse_bank_top
`default_nettype wire

// file: tb_cse_bank_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_cse_bank_top import cse_pkg::*;;
  localparam logic [15:0] FR = 16'h0010;
  logic        clk_sys, rst_n, avs_read, avs_write, avs_waitrequest, frame_start, led_on;
  logic        frame_enable, state_skip, frame_discard;
  logic [8:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd, rnd, got;
  logic [3:0]  avs_byteenable, wx, wy, ww, wh;
  logic [1:0]  seq_state;
  logic [15:0] wake_row;
  logic [7:0]  goal, tol, rate, stepd, o, d, po, pd;
  logic [7:0]  tv [4];
  cse_exp_t    exp_mode;
  cse_flk_t    flk_mode;
  cse_bal_t    bal_mode;
  cse_his_t    his_mode;
  int          n_fail, n_tests, cnt;
  int          nv [4] = '{5, 3, 4, 4};
  logic [6:0]  ix_t [4] = '{IX_GOAL, IX_TOLERANCE, IX_UPD_RATE, IX_STEP_DIV};
  logic [6:0]  ix_r [7] = '{IX_RSVD_PTR, IX_WIN_ORG, IX_WIN_DIM, IX_GOAL, IX_TOLERANCE, IX_UPD_RATE, IX_STEP_DIV};
  logic [15:0] rv_r [7] = '{16'he87e, 16'h0000, 16'h00ef, 16'h003c, 16'h000a, 16'h0000, 16'h0002};

  cse_bank_top #(.FRAME_ROWS(FR)) u_cse_bank_top (
    .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .seq_state(seq_state),
    .frame_start(frame_start), .led_on(led_on), .exp_mode(exp_mode), .flk_mode(flk_mode),
    .bal_mode(bal_mode), .his_mode(his_mode), .frame_enable(frame_enable), .state_skip(state_skip),
    .frame_discard(frame_discard), .win_x_origin(wx), .win_y_origin(wy), .win_width_m1(ww),
    .win_height_m1(wh), .wake_row(wake_row), .brightness_goal(goal), .exposure_tolerance(tol),
    .exposure_update_rate(rate), .exposure_step_divisor(stepd));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] oh(input int v, input int n);
    return (v < n) ? (32'h1 << v) : 32'h1;
  endfunction
  function automatic logic [15:0] wake_exp(input logic [7:0] og, input logic [7:0] dm);
    return 16'(((og[7:4] + 4 * (dm[7:4] + 1)) * FR) >> 4);
  endfunction
  function automatic logic [8:0] ba(input logic [6:0] ix);
    return {ix, 2'b00};
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string what);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, g, e);
    end
  endtask

  // Request held until waitrequest is sampled low
  task automatic bus(input logic we, input logic [8:0] ad, input logic [7:0] dt);
    int n;
    n = 0;
    rnd = lfsr(rnd);
    avs_address <= ad;
    avs_write <= we;
    avs_read <= !we;
    avs_writedata <= {rnd[31:8], dt};
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0 && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    chk(32'(n < 20), 32'h1, "no answer");
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic pulse(input logic led, output int c);
    led_on <= led;
    frame_start <= 1'b1;
    @(posedge clk_sys);
    frame_start <= 1'b0;
    c = 0;
    repeat (4) begin
      @(posedge clk_sys);
      c += int'(frame_discard !== 1'b0);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    conclude;
  end

  initial begin
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 9'h000;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h1;
    seq_state = 2'h0;
    frame_start = 1'b0;
    led_on = 1'b0;
    rnd = 32'ha78d;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    for (int s = 0; s < NUM_STATES; s++) begin
      for (int f = 0; f < NUM_FIELDS; f++) begin
        bus(1'b0, ba(IX_PS[s][f]), 8'h00);
        chk(rd, {24'h0, RST_PS[s][f]}, "state reset");
      end
    end
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, ba(ix_r[i]), 8'h00);
      chk(rd, {16'h0, rv_r[i]}, "reg reset");
    end
    chk({goal, tol, rate, stepd}, 32'h3c0a0002, "tuning ports");
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      seq_state <= rnd[1:0];
      @(posedge clk_sys);
      for (int v = 0; v <= nv[k]; v++) begin
        bus(1'b1, ba(IX_PS[seq_state][k]), 8'(v));
        repeat (3) @(posedge clk_sys);
        got = (k == 0) ? 32'(exp_mode) : (k == 1) ? 32'(flk_mode) : (k == 2) ? 32'(bal_mode) : 32'(his_mode);
        chk(got, oh(v, nv[k]), "mode decode");
      end
    end
    $display("test decode done");
    seq_state <= 2'h1;
    bus(1'b1, ba(IX_PS[1][F_SKIP]), 8'hc0);
    repeat (3) @(posedge clk_sys);
    chk({frame_enable, state_skip}, 32'h1, "skip high bits");
    bus(1'b1, ba(IX_PS[1][F_SKIP]), 8'h20);
    seq_state <= 2'h2;
    @(posedge clk_sys);
    seq_state <= 2'h1;
    repeat (3) @(posedge clk_sys);
    chk({frame_enable, state_skip}, 32'h2, "skip bit5 only");
    pulse(1'b1, cnt);
    chk(cnt, 32'h1, "first frame drop");
    pulse(1'b1, cnt);
    chk(cnt, 32'h0, "second frame kept");
    seq_state <= 2'h3;
    @(posedge clk_sys);
    seq_state <= 2'h1;
    repeat (3) @(posedge clk_sys);
    pulse(1'b0, cnt);
    chk(cnt, 32'h0, "led off kept");
    $display("test skip done");
    po = 8'h00;
    pd = 8'hef;
    repeat (3) begin
      o = rnd[7:0];
      d = rnd[15:8];
      bus(1'b1, ba(IX_WIN_ORG), o);
      bus(1'b1, ba(IX_WIN_DIM), d);
      bus(1'b1, ba(IX_SEQ_CMD), 8'h05);
      repeat (4) @(posedge clk_sys);
      chk({wy, wx, wh, ww}, {16'h0, po, pd}, "window held");
      bus(1'b0, ba(IX_WIN_ORG), 8'h00);
      chk(rd, {24'h0, o}, "shadow org");
      bus(1'b1, ba(IX_SEQ_CMD), CMD_REFRESH);
      repeat (4) @(posedge clk_sys);
      chk({wy, wx, wh, ww}, {16'h0, o, d}, "window live");
      chk(wake_row, wake_exp(o, d), "wake port");
      bus(1'b1, ba(IX_WAKE_ROW), 8'h55);
      bus(1'b0, ba(IX_WAKE_ROW), 8'h00);
      chk(rd, {16'h0, wake_exp(o, d)}, "wake reg");
      po = o;
      pd = d;
    end
    $display("test window done");
    for (int i = 0; i < 4; i++) begin
      tv[i] = rnd[7:0];
      bus(1'b1, ba(ix_t[i]), tv[i]);
    end
    avs_byteenable <= 4'h0;
    bus(1'b1, ba(IX_GOAL), ~tv[0]);
    avs_byteenable <= 4'h1;
    bus(1'b0, ba(IX_GOAL), 8'h00);
    chk(rd, {24'h0, tv[0]}, "lane off write");
    chk({goal, tol, rate, stepd}, {tv[0], tv[1], tv[2], tv[3]}, "tuning ports");
    bus(1'b0, 9'h1f4, 8'h00);
    chk(rd, 32'h0, "unmapped read");
    bus(1'b0, 9'h019, 8'h00);
    chk(rd, 32'h0, "misaligned read");
    bus(1'b0, ba(IX_BANK_STAT), 8'h00);
    chk(rd, 32'h9, "status sticky");
    bus(1'b1, ba(IX_BANK_STAT), 8'h08);
    bus(1'b0, ba(IX_BANK_STAT), 8'h00);
    chk(rd, 32'h1, "status cleared");
    $display("test tuning done");
    conclude;
  end
endmodule // tb_cse_bank_top
`default_nettype wire
